//--- verilog/nas_pkg.sv
`default_nettype none
package nas_pkg;
    // instruction word: prefix, row, column, low nibble
    localparam int INSTR_W = 16;
    localparam int OPC_LSB = 11;
    localparam int OPC_W = 5;
    localparam int ROW_LSB = 8;
    localparam int ROW_W = 3;
    localparam int COL_LSB = 4;
    localparam int NIB_W = 4;
    localparam int DADDR_W = 12;
    localparam int IX_W = 12;
    localparam int AR_MAX_W = 12;
    localparam int AR_W_DEFAULT = 11;
    localparam logic [OPC_W-1:0] OPC_ADD_WITH_CARRY_OP_IMM = 5'h12;
    localparam logic [OPC_W-1:0] OPC_SUB_RM = 5'h01;
    localparam logic [OPC_W-1:0] OPC_INC_AR = 5'h1d;
    localparam logic [OPC_W-1:0] OPC_INC_IX = 5'h1e;
    // register port
    localparam int RA_W = 4;
    localparam int RD_W = 8;
    localparam logic [RA_W-1:0] REG_FLAGS = 4'h0;
    localparam logic [RA_W-1:0] REG_IX_LOW = 4'h1;
    localparam logic [RA_W-1:0] REG_IX_MID = 4'h2;
    localparam logic [RA_W-1:0] REG_IX_HIGH = 4'h3;
    localparam logic [RA_W-1:0] REG_AR_LOW = 4'h4;
    localparam logic [RA_W-1:0] REG_AR_MID = 4'h5;
    localparam logic [RA_W-1:0] REG_AR_HIGH = 4'h6;
    localparam logic [RA_W-1:0] REG_GREG_ROW = 4'h7;
    localparam logic [RA_W-1:0] REG_STATUS = 4'h8;
    // flag register bit positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_CMP = 2;
    localparam int FLAG_BCD = 3;
    localparam int FLAG_IXE = 4;
    localparam int FLAGS_W = 5;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 5'h00;
    // status register bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_ILLEGAL = 1;
    localparam logic [NIB_W-1:0] BCD_MAX = 4'h9;
    localparam logic [NIB_W:0] BCD_ADJ = 5'h06;
    typedef enum logic [2:0] {
        NAS_ST_IDLE = 3'b001,
        NAS_ST_READ = 3'b010,
        NAS_ST_EXEC = 3'b100
    } nas_state_type;
endpackage
`default_nettype wire

//--- verilog/nas_alu_if.sv
`default_nettype none
interface nas_alu_if;
    import nas_pkg::*;
    logic [NIB_W-1:0] a;
    logic [NIB_W-1:0] b;
    logic cin;
    logic sub;
    logic bcd;
    logic [NIB_W-1:0] result;
    logic cout;
    modport ctrl (output a, output b, output cin, output sub, output bcd, input result, input cout);
    modport alu (input a, input b, input cin, input sub, input bcd, output result, output cout);
endinterface
`default_nettype wire

//--- verilog/nas_nibble_alu.sv
`default_nettype none
module nas_nibble_alu (
    nas_alu_if.alu bus
);
    import nas_pkg::*;
    logic [NIB_W:0] raw;
    logic [NIB_W:0] adj;
    logic over;
    always_comb begin
        if (bus.sub) begin
            raw = {1'b0, bus.a} - {1'b0, bus.b} - {4'h0, bus.cin};
            over = raw[NIB_W];
            // decimal borrow: fold back by six so the digit stays in 0..9
            adj = (bus.bcd && over) ? raw - BCD_ADJ : raw;
        end else begin
            raw = {1'b0, bus.a} + {1'b0, bus.b} + {4'h0, bus.cin};
            over = bus.bcd ? (raw > {1'b0, BCD_MAX}) : raw[NIB_W];
            adj = (bus.bcd && over) ? raw + BCD_ADJ : raw;
        end
        bus.result = adj[NIB_W-1:0];
        bus.cout = over;
    end
endmodule
`default_nettype wire

//--- verilog/nas_ptr_inc.sv
`default_nettype none
module nas_ptr_inc #(
    parameter int WIDTH = 12
) (
    input wire logic [WIDTH-1:0] value_i,
    output logic [WIDTH-1:0] value_o
);
    import nas_pkg::*;
    localparam int NIBS = (WIDTH + NIB_W - 1) / NIB_W;
    logic [NIBS:0] carry;
    logic [NIBS*NIB_W-1:0] wide_in;
    logic [NIBS*NIB_W-1:0] wide_out;
    assign carry[0] = 1'b1;
    assign wide_in = {{(NIBS*NIB_W-WIDTH){1'b0}}, value_i};
    // carry ripples nibble by nibble, lowest first
    for (genvar g = 0; g < NIBS; g++) begin : g_nib
        logic [NIB_W:0] s;
        assign s = {1'b0, wide_in[g*NIB_W +: NIB_W]} + {4'h0, carry[g]};
        assign wide_out[g*NIB_W +: NIB_W] = s[NIB_W-1:0];
        assign carry[g+1] = s[NIB_W];
    end
    // bits above the width are not built, so the pointer wraps
    assign value_o = wide_out[WIDTH-1:0];
endmodule
`default_nettype wire

//--- verilog/nas_alu_top.sv
// How it works
// - the add-immediate-with-carry is recognised by prefix 10010 followed by row, column and immediate nibble.
// - with compare clear, add-immediate-with-carry writes memory plus immediate plus carry back to memory.
// - with compare set, add-immediate-with-carry leaves memory alone but still updates carry and zero.
// - an addition sets carry on carry out and clears it otherwise.
// - a nonzero sum clears the zero flag whatever compare is.
// - a zero result sets zero when compare is clear and leaves it alone when compare is set.
// - addition is binary when decimal mode is clear and decimal-adjusted when it is set.
// - the table-address increment adds one, carrying from the lowest nibble to the highest.
// - the table address pointer is ten or eleven bits wide by variant; higher bits do not exist.
// - the index increment adds one to the twelve-bit index built from low, middle and high nibbles.
// - with compare clear, register-minus-memory stores the difference into the general register.
// - with compare set, register-minus-memory keeps the register but updates carry and zero.
// - a subtraction sets carry on borrow and clears it otherwise.
// - a nonzero difference clears the zero flag whatever compare is.
// - subtraction is binary when decimal mode is clear and decimal-adjusted when it is set.
// - with index enable set, the memory operand address is the index OR the instruction address.
//
// Added by the designer: the plain strobed port and the register offsets.
`default_nettype none
module nas_alu_top #(
    parameter int AR_W = nas_pkg::AR_W_DEFAULT
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // instruction issue from the decoder
    input wire logic instr_valid_i,
    input wire logic [nas_pkg::INSTR_W-1:0] instr_i,
    output logic instr_ready_o,
    // data memory port, read data one cycle after the read strobe
    output logic [nas_pkg::DADDR_W-1:0] dmem_addr_o,
    output logic dmem_rd_o,
    output logic dmem_wr_o,
    output logic [nas_pkg::NIB_W-1:0] dmem_wdata_o,
    input wire logic [nas_pkg::NIB_W-1:0] dmem_rdata_i,
    // general register port, same timing
    output logic [nas_pkg::ROW_W+nas_pkg::NIB_W-1:0] greg_addr_o,
    output logic greg_rd_o,
    output logic greg_wr_o,
    output logic [nas_pkg::NIB_W-1:0] greg_wdata_o,
    input wire logic [nas_pkg::NIB_W-1:0] greg_rdata_i,
    // pointer views for table read and indirect logic
    output logic [AR_W-1:0] table_address_pointer_o,
    output logic [nas_pkg::IX_W-1:0] index_pointer_o,
    // register port
    input wire logic [nas_pkg::RA_W-1:0] reg_addr_i,
    input wire logic [nas_pkg::RD_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [nas_pkg::RD_W-1:0] reg_rdata_o
);
    import nas_pkg::*;

    nas_state_type state_q;
    nas_state_type state_d;
    logic instr_ready_q;
    logic [OPC_W-1:0] opc_q;
    logic [NIB_W-1:0] imm_q;
    logic [NIB_W-1:0] col_q;
    logic [DADDR_W-1:0] dmem_addr_q;
    logic dmem_rd_q;
    logic dmem_wr_q;
    logic [NIB_W-1:0] dmem_wdata_q;
    logic [ROW_W+NIB_W-1:0] greg_addr_q;
    logic greg_rd_q;
    logic greg_wr_q;
    logic [NIB_W-1:0] greg_wdata_q;
    logic [RD_W-1:0] reg_rdata_q;
    logic carry_flag_q;
    logic zero_flag_q;
    logic compare_flag_q;
    logic bcd_flag_q;
    logic index_enable_flag_q;
    logic [IX_W-1:0] index_pointer_q;
    logic [AR_W-1:0] table_address_pointer_q;
    logic [ROW_W-1:0] greg_row_q;
    logic illegal_q;

    // decode of the incoming word
    logic accept;
    logic [OPC_W-1:0] in_opc;
    logic [ROW_W-1:0] in_row;
    logic [NIB_W-1:0] in_col;
    logic [NIB_W-1:0] in_low;
    logic in_add_with_carry_op;
    logic in_sub;
    logic in_inc_ar;
    logic in_inc_ix;
    logic in_known;
    logic [DADDR_W-1:0] operand_addr;
    logic [DADDR_W-1:0] eff_addr;

    assign accept = instr_valid_i && instr_ready_q;
    assign in_opc = instr_i[OPC_LSB +: OPC_W];
    assign in_row = instr_i[ROW_LSB +: ROW_W];
    assign in_col = instr_i[COL_LSB +: NIB_W];
    assign in_low = instr_i[NIB_W-1:0];
    assign in_add_with_carry_op = (in_opc == OPC_ADD_WITH_CARRY_OP_IMM);
    assign in_sub = (in_opc == OPC_SUB_RM);
    assign in_inc_ar = (in_opc == OPC_INC_AR);
    assign in_inc_ix = (in_opc == OPC_INC_IX);
    assign in_known = in_add_with_carry_op || in_sub || in_inc_ar || in_inc_ix;
    assign operand_addr = {{(DADDR_W-ROW_W-NIB_W){1'b0}}, in_row, in_col};
    assign eff_addr = index_enable_flag_q ? (operand_addr | index_pointer_q) : operand_addr;

    // incrementers
    logic [AR_W-1:0] ar_next;
    logic [IX_W-1:0] ix_next;

    nas_ptr_inc #(
        .WIDTH(AR_W)
    ) u_ar_inc (
        .value_i(table_address_pointer_q),
        .value_o(ar_next)
    );

    nas_ptr_inc #(
        .WIDTH(IX_W)
    ) u_ix_inc (
        .value_i(index_pointer_q),
        .value_o(ix_next)
    );

    // nibble arithmetic
    nas_alu_if alu_bus ();

    nas_nibble_alu u_alu (
        .bus(alu_bus)
    );

    logic exec_add;
    logic exec_sub;
    logic exec_any;

    assign exec_add = (state_q == NAS_ST_EXEC) && (opc_q == OPC_ADD_WITH_CARRY_OP_IMM);
    assign exec_sub = (state_q == NAS_ST_EXEC) && (opc_q == OPC_SUB_RM);
    assign exec_any = exec_add || exec_sub;

    always_comb begin
        alu_bus.sub = exec_sub;
        alu_bus.bcd = bcd_flag_q;
        if (exec_sub) begin
            alu_bus.a = greg_rdata_i;
            alu_bus.b = dmem_rdata_i;
            alu_bus.cin = 1'b0;
        end else begin
            alu_bus.a = dmem_rdata_i;
            alu_bus.b = imm_q;
            alu_bus.cin = carry_flag_q;
        end
    end

    logic result_zero;
    assign result_zero = (alu_bus.result == '0);

    // sequencing: idle, operand read, execute
    always_comb begin
        state_d = state_q;
        case (state_q)
            NAS_ST_IDLE: begin
                if (accept && (in_add_with_carry_op || in_sub)) begin
                    state_d = NAS_ST_READ;
                end
            end
            NAS_ST_READ: begin
                state_d = NAS_ST_EXEC;
            end
            NAS_ST_EXEC: begin
                state_d = NAS_ST_IDLE;
            end
            default: begin
                state_d = NAS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= NAS_ST_IDLE;
            instr_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            instr_ready_q <= (state_d == NAS_ST_IDLE);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opc_q <= '0;
            imm_q <= '0;
            col_q <= '0;
        end else if (accept) begin
            opc_q <= in_opc;
            imm_q <= in_low;
            col_q <= in_col;
        end
    end

    // operand reads: strobes stand one cycle, data come back in execute
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dmem_addr_q <= '0;
            dmem_rd_q <= 1'b0;
            greg_addr_q <= '0;
            greg_rd_q <= 1'b0;
        end else begin
            dmem_rd_q <= accept && (in_add_with_carry_op || in_sub);
            greg_rd_q <= accept && in_sub;
            if (accept && (in_add_with_carry_op || in_sub)) begin
                dmem_addr_q <= eff_addr;
            end
            if (accept && in_sub) begin
                // register operand sits in the low nibble of the word
                greg_addr_q <= {greg_row_q, in_low};
            end
        end
    end

    // write-back is suppressed while compare is set
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dmem_wr_q <= 1'b0;
            dmem_wdata_q <= '0;
            greg_wr_q <= 1'b0;
            greg_wdata_q <= '0;
        end else begin
            dmem_wr_q <= exec_add && !compare_flag_q;
            greg_wr_q <= exec_sub && !compare_flag_q;
            if (exec_add) begin
                dmem_wdata_q <= alu_bus.result;
            end
            if (exec_sub) begin
                greg_wdata_q <= alu_bus.result;
            end
        end
    end

    logic flags_wr;
    assign flags_wr = reg_wr_i && (reg_addr_i == REG_FLAGS);

    // hardware flag updates win over a software write in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carry_flag_q <= FLAGS_RESET[FLAG_CARRY];
            zero_flag_q <= FLAGS_RESET[FLAG_ZERO];
            compare_flag_q <= FLAGS_RESET[FLAG_CMP];
            bcd_flag_q <= FLAGS_RESET[FLAG_BCD];
            index_enable_flag_q <= FLAGS_RESET[FLAG_IXE];
        end else begin
            if (flags_wr) begin
                compare_flag_q <= reg_wdata_i[FLAG_CMP];
                bcd_flag_q <= reg_wdata_i[FLAG_BCD];
                index_enable_flag_q <= reg_wdata_i[FLAG_IXE];
            end
            if (exec_any) begin
                carry_flag_q <= alu_bus.cout;
            end else if (flags_wr) begin
                carry_flag_q <= reg_wdata_i[FLAG_CARRY];
            end
            if (exec_any && !result_zero) begin
                zero_flag_q <= 1'b0;
            end else if (exec_any && !compare_flag_q) begin
                zero_flag_q <= 1'b1;
            end else if (exec_any) begin
                // compare chains keep the zero left by earlier nibbles
                zero_flag_q <= zero_flag_q;
            end else if (flags_wr) begin
                zero_flag_q <= reg_wdata_i[FLAG_ZERO];
            end
        end
    end

    // pointers: an increment wins over a software write in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            index_pointer_q <= '0;
        end else if (accept && in_inc_ix) begin
            index_pointer_q <= ix_next;
        end else if (reg_wr_i && (reg_addr_i == REG_IX_LOW)) begin
            index_pointer_q[0 +: NIB_W] <= reg_wdata_i[NIB_W-1:0];
        end else if (reg_wr_i && (reg_addr_i == REG_IX_MID)) begin
            index_pointer_q[NIB_W +: NIB_W] <= reg_wdata_i[NIB_W-1:0];
        end else if (reg_wr_i && (reg_addr_i == REG_IX_HIGH)) begin
            index_pointer_q[2*NIB_W +: NIB_W] <= reg_wdata_i[NIB_W-1:0];
        end
    end

    // software writes land in a full-width view, then only AR_W bits are kept
    logic [AR_MAX_W-1:0] ar_wide;
    logic [AR_MAX_W-1:0] ar_written;
    assign ar_wide = {{(AR_MAX_W-AR_W){1'b0}}, table_address_pointer_q};

    always_comb begin
        ar_written = ar_wide;
        if (reg_addr_i == REG_AR_LOW) begin
            ar_written[0 +: NIB_W] = reg_wdata_i[NIB_W-1:0];
        end else if (reg_addr_i == REG_AR_MID) begin
            ar_written[NIB_W +: NIB_W] = reg_wdata_i[NIB_W-1:0];
        end else if (reg_addr_i == REG_AR_HIGH) begin
            ar_written[2*NIB_W +: NIB_W] = reg_wdata_i[NIB_W-1:0];
        end
    end

    logic ar_wr;
    assign ar_wr = reg_wr_i && ((reg_addr_i == REG_AR_LOW) || (reg_addr_i == REG_AR_MID)
        || (reg_addr_i == REG_AR_HIGH));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            table_address_pointer_q <= '0;
        end else if (accept && in_inc_ar) begin
            table_address_pointer_q <= ar_next;
        end else if (ar_wr) begin
            table_address_pointer_q <= ar_written[AR_W-1:0];
        end
    end

    // general register row and sticky illegal-opcode flag
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            greg_row_q <= '0;
        end else if (reg_wr_i && (reg_addr_i == REG_GREG_ROW)) begin
            greg_row_q <= reg_wdata_i[ROW_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            illegal_q <= 1'b0;
        end else if (accept && !in_known) begin
            illegal_q <= 1'b1;
        end else if (reg_wr_i && (reg_addr_i == REG_STATUS) && reg_wdata_i[STAT_ILLEGAL]) begin
            illegal_q <= 1'b0;
        end
    end

    // register read-back, one cycle after the read strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_q <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_q <= '0;
            case (reg_addr_i)
                REG_FLAGS: begin
                    reg_rdata_q[FLAG_CARRY] <= carry_flag_q;
                    reg_rdata_q[FLAG_ZERO] <= zero_flag_q;
                    reg_rdata_q[FLAG_CMP] <= compare_flag_q;
                    reg_rdata_q[FLAG_BCD] <= bcd_flag_q;
                    reg_rdata_q[FLAG_IXE] <= index_enable_flag_q;
                end
                REG_IX_LOW: reg_rdata_q[NIB_W-1:0] <= index_pointer_q[0 +: NIB_W];
                REG_IX_MID: reg_rdata_q[NIB_W-1:0] <= index_pointer_q[NIB_W +: NIB_W];
                REG_IX_HIGH: reg_rdata_q[NIB_W-1:0] <= index_pointer_q[2*NIB_W +: NIB_W];
                REG_AR_LOW: reg_rdata_q[NIB_W-1:0] <= ar_wide[0 +: NIB_W];
                REG_AR_MID: reg_rdata_q[NIB_W-1:0] <= ar_wide[NIB_W +: NIB_W];
                REG_AR_HIGH: reg_rdata_q[NIB_W-1:0] <= ar_wide[2*NIB_W +: NIB_W];
                REG_GREG_ROW: reg_rdata_q[ROW_W-1:0] <= greg_row_q;
                REG_STATUS: begin
                    reg_rdata_q[STAT_BUSY] <= (state_q != NAS_ST_IDLE);
                    reg_rdata_q[STAT_ILLEGAL] <= illegal_q;
                end
                default: reg_rdata_q <= '0;
            endcase
        end
    end

    assign instr_ready_o = instr_ready_q;
    assign dmem_addr_o = dmem_addr_q;
    assign dmem_rd_o = dmem_rd_q;
    assign dmem_wr_o = dmem_wr_q;
    assign dmem_wdata_o = dmem_wdata_q;
    assign greg_addr_o = greg_addr_q;
    assign greg_rd_o = greg_rd_q;
    assign greg_wr_o = greg_wr_q;
    assign greg_wdata_o = greg_wdata_q;
    assign table_address_pointer_o = table_address_pointer_q;
    assign index_pointer_o = index_pointer_q;
    assign reg_rdata_o = reg_rdata_q;

    // col_q kept for debug visibility of the last operand column
    logic unused_col;
    assign unused_col = ^col_q;
endmodule
`default_nettype wire

//--- testbench/nas_alu_assertions.sv
`default_nettype none
module nas_alu_assertions #(
    parameter int AR_W = 11
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [nas_pkg::INSTR_W-1:0] instr_i,
    input wire logic instr_ready_o,
    input wire logic [nas_pkg::DADDR_W-1:0] dmem_addr_o,
    input wire logic dmem_rd_o,
    input wire logic dmem_wr_o,
    input wire logic [nas_pkg::ROW_W+nas_pkg::NIB_W-1:0] greg_addr_o,
    input wire logic greg_rd_o,
    input wire logic greg_wr_o,
    input wire logic [AR_W-1:0] table_address_pointer_o,
    input wire logic [nas_pkg::IX_W-1:0] index_pointer_o,
    input wire logic [nas_pkg::RA_W-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [nas_pkg::RD_W-1:0] reg_rdata_o
);
    import nas_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic tk;
    logic [OPC_W-1:0] op;
    assign tk = instr_valid_i && instr_ready_o;
    assign op = instr_i[OPC_LSB+:OPC_W];
    property p_add_with_carry_op_read;
        tk && op == OPC_ADD_WITH_CARRY_OP_IMM |=> dmem_rd_o && !greg_rd_o && !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o;
    endproperty
    a_add_with_carry_op_read: assert property (p_add_with_carry_op_read) else $error("add immediate not started");
    property p_sub_seq;
        tk && op == OPC_SUB_RM |=> dmem_rd_o && greg_rd_o ##2 !dmem_wr_o;
    endproperty
    a_sub_seq: assert property (p_sub_seq) else $error("subtract sequence wrong");
    property p_wr_addr;
        dmem_wr_o |-> $past(dmem_rd_o, 2) && dmem_addr_o == $past(dmem_addr_o, 2);
    endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("memory write not at read place");
    property p_greg_wr;
        greg_wr_o |-> $past(greg_rd_o, 2) && greg_addr_o == $past(greg_addr_o, 2);
    endproperty
    a_greg_wr: assert property (p_greg_wr) else $error("register write not at read place");
    property p_eff_addr;
        tk && (op == OPC_ADD_WITH_CARRY_OP_IMM || op == OPC_SUB_RM) |=>
            (dmem_addr_o & 12'($past(instr_i[10:4]))) == 12'($past(instr_i[10:4]))
            && (dmem_addr_o & ~(index_pointer_o | 12'($past(instr_i[10:4])))) == 12'h000;
    endproperty
    a_eff_addr: assert property (p_eff_addr) else $error("operand address wrong");
    property p_ar_inc;
        tk && op == OPC_INC_AR |=> table_address_pointer_o == $past(table_address_pointer_o) + 1'b1;
    endproperty
    a_ar_inc: assert property (p_ar_inc) else $error("table pointer step wrong");
    property p_ix_inc;
        tk && op == OPC_INC_IX |=> index_pointer_o == $past(index_pointer_o) + 1'b1;
    endproperty
    a_ix_inc: assert property (p_ix_inc) else $error("index step wrong");
    property p_rd_gap;
        dmem_rd_o |=> !dmem_rd_o ##1 !dmem_rd_o;
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("reads too close");
    property p_unmapped;
        reg_rd_i && reg_addr_i > REG_STATUS |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_dwr: cover property (dmem_wr_o);
    c_gwr: cover property (greg_wr_o);
    c_wrap: cover property (tk && op == OPC_INC_AR && &table_address_pointer_o);
endmodule
`default_nettype wire

//--- testbench/nas_mem_model.sv
`default_nettype none
module nas_mem_model (
    input wire logic clk_sys_i,
    input wire logic [nas_pkg::DADDR_W-1:0] dmem_addr_i,
    input wire logic dmem_rd_i,
    input wire logic dmem_wr_i,
    input wire logic [nas_pkg::NIB_W-1:0] dmem_wdata_i,
    output logic [nas_pkg::NIB_W-1:0] dmem_rdata_o,
    input wire logic [nas_pkg::ROW_W+nas_pkg::NIB_W-1:0] greg_addr_i,
    input wire logic greg_rd_i,
    input wire logic greg_wr_i,
    input wire logic [nas_pkg::NIB_W-1:0] greg_wdata_i,
    output logic [nas_pkg::NIB_W-1:0] greg_rdata_o
);
    import nas_pkg::*;
    logic [NIB_W-1:0] dmem [2**DADDR_W];
    logic [NIB_W-1:0] greg [2**(ROW_W+NIB_W)];
    initial dmem_rdata_o = 4'h0;
    initial greg_rdata_o = 4'h0;
    // data is valid for one cycle only; the line toggles otherwise so a late sample shows
    always @(posedge clk_sys_i) begin
        dmem_rdata_o <= dmem_rd_i ? dmem[dmem_addr_i] : ~dmem_rdata_o;
        greg_rdata_o <= greg_rd_i ? greg[greg_addr_i] : ~greg_rdata_o;
        if (dmem_wr_i) begin
            dmem[dmem_addr_i] <= dmem_wdata_i;
        end
        if (greg_wr_i) begin
            greg[greg_addr_i] <= greg_wdata_i;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import nas_pkg::*;
    localparam int AR_W = 10;
    logic clk = 1'b0, rst_n = 1'b0, iv = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [INSTR_W-1:0] iw = '0;
    logic [RA_W-1:0] ra = '0;
    logic [RD_W-1:0] rwd = '0, rdo, r;
    logic rdy, drd, dwr, grd, gwr;
    logic [DADDR_W-1:0] da;
    logic [NIB_W-1:0] dwd, drdat, gwd, grdat;
    logic [6:0] ga;
    logic [AR_W-1:0] ar;
    logic [IX_W-1:0] ix;
    int n_mismatch = 0, comparisons = 0;
    // {subtract, ixe bcd cmp zero carry, first operand, second operand}
    logic [13:0] tc [9] = '{{1'b0, 5'h01, 4'h9, 4'h6}, {1'b0, 5'h04, 4'h8, 4'h8}, {1'b0, 5'h06, 4'h3, 4'h4},
        {1'b0, 5'h08, 4'h7, 4'h5}, {1'b0, 5'h11, 4'h2, 4'h3}, {1'b1, 5'h01, 4'h5, 4'h7},
        {1'b1, 5'h04, 4'h6, 4'h6}, {1'b1, 5'h0a, 4'h3, 4'h5}, {1'b1, 5'h10, 4'h9, 4'h4}};
    nas_alu_top #(.AR_W(AR_W)) i_nas_alu_top (.clk_sys_i(clk), .rst_n_i(rst_n), .instr_valid_i(iv),
        .instr_i(iw), .instr_ready_o(rdy), .dmem_addr_o(da), .dmem_rd_o(drd), .dmem_wr_o(dwr),
        .dmem_wdata_o(dwd), .dmem_rdata_i(drdat), .greg_addr_o(ga), .greg_rd_o(grd), .greg_wr_o(gwr),
        .greg_wdata_o(gwd), .greg_rdata_i(grdat), .table_address_pointer_o(ar), .index_pointer_o(ix),
        .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdo));
    nas_mem_model i_nas_mem_model (.clk_sys_i(clk), .dmem_addr_i(da), .dmem_rd_i(drd), .dmem_wr_i(dwr),
        .dmem_wdata_i(dwd), .dmem_rdata_o(drdat), .greg_addr_i(ga), .greg_rd_i(grd), .greg_wr_i(gwr),
        .greg_wdata_i(gwd), .greg_rdata_o(grdat));
    initial begin
        forever #20 clk = ~clk;
    end
    task end_of_test;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
        @(posedge clk);
        ra <= a;
        rwd <= d;
        rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task rdr(input logic [RA_W-1:0] a);
        @(posedge clk);
        ra <= a;
        rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        @(posedge clk);
        r = rdo;
    endtask
    // one word offered until taken, then held off until the block is idle again
    task issue(input logic [INSTR_W-1:0] w);
        int i;
        i = 0;
        @(posedge clk);
        iv <= 1'b1;
        iw <= w;
        do begin
            @(posedge clk);
            i++;
        end while (rdy !== 1'b1 && i < 8);
        iv <= 1'b0;
        do begin
            @(posedge clk);
            i++;
        end while (rdy !== 1'b1 && i < 16);
        if (i >= 16) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task t_op(input logic [13:0] c);
        logic [4:0] s, f;
        logic [DADDR_W-1:0] a;
        f = c[12:8];
        a = f[FLAG_IXE] ? 12'h06f : 12'h02f;
        s = c[13] ? {1'b0, c[7:4]} - {1'b0, c[3:0]} : {1'b0, c[7:4]} + {1'b0, c[3:0]} + f[FLAG_CARRY];
        if (f[FLAG_BCD] && !c[13] && s > 5'h09) begin
            s = {1'b1, s[3:0] + 4'h6};
        end
        if (f[FLAG_BCD] && c[13] && s[4]) begin
            s = {1'b1, s[3:0] - 4'h6};
        end
        i_nas_mem_model.dmem[a] = c[13] ? c[3:0] : c[7:4];
        i_nas_mem_model.greg[7'h13] = c[7:4];
        wr(REG_FLAGS, {3'h0, f});
        issue({c[13] ? OPC_SUB_RM : OPC_ADD_WITH_CARRY_OP_IMM, 3'h2, 4'hf, c[13] ? 4'h3 : c[3:0]});
        rdr(REG_FLAGS);
        f[FLAG_CARRY] = s[4];
        f[FLAG_ZERO] = (s[3:0] != 4'h0) ? 1'b0 : (f[FLAG_CMP] ? f[FLAG_ZERO] : 1'b1);
        chk(12'(r), {7'h00, f});
        s[3:0] = f[FLAG_CMP] ? c[7:4] : s[3:0];
        chk(12'(c[13] ? i_nas_mem_model.greg[7'h13] : i_nas_mem_model.dmem[a]), 12'(s[3:0]));
    endtask
    task t_ptr;
        wr(REG_AR_HIGH, 8'h0f);
        rdr(REG_AR_HIGH);
        chk(12'(r), 12'h003);
        wr(REG_AR_LOW, 8'h0f);
        wr(REG_AR_MID, 8'h0f);
        issue({OPC_INC_AR, 11'h000});
        chk(12'(ar), 12'h000);
        issue({OPC_INC_AR, 11'h000});
        chk(12'(ar), 12'h001);
        wr(REG_IX_LOW, 8'h0f);
        wr(REG_IX_MID, 8'h0f);
        issue({OPC_INC_IX, 11'h000});
        chk(ix, 12'h100);
        wr(REG_IX_HIGH, 8'h0f);
        wr(REG_IX_MID, 8'h0f);
        wr(REG_IX_LOW, 8'h0f);
        issue({OPC_INC_IX, 11'h000});
        chk(ix, 12'h000);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rdr(REG_FLAGS);
        chk(12'(r), 12'(FLAGS_RESET));
        rdr(4'hc);
        chk(12'(r), 12'h000);
        issue(16'h0000);
        rdr(REG_STATUS);
        chk(12'(r), 12'h002);
        wr(REG_GREG_ROW, 8'h01);
        wr(REG_IX_MID, 8'h04);
        for (int k = 0; k < 9; k++) begin
            t_op(tc[k]);
        end
        t_ptr();
        end_of_test();
    end
endmodule
bind nas_alu_top nas_alu_assertions #(.AR_W(AR_W)) i_nas_alu_assertions (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
    .dmem_addr_o(dmem_addr_o), .dmem_rd_o(dmem_rd_o), .dmem_wr_o(dmem_wr_o), .greg_addr_o(greg_addr_o),
    .greg_rd_o(greg_rd_o), .greg_wr_o(greg_wr_o), .table_address_pointer_o(table_address_pointer_o),
    .index_pointer_o(index_pointer_o), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire
